// ===== hw/dsfd_pkg.sv
package dsfd_pkg;
    // Serial word layout
    localparam int WORD_W    = 24;
    localparam int MODE_HI   = 23;
    localparam int MODE_LO   = 22;
    localparam int CODE_HI   = 21;
    localparam int CODE_LO   = 16;
    localparam int PAY_W     = 16;
    localparam int OFS_W     = 14;
    localparam int ABS_W     = 8;
    localparam int ABS_N     = 4;
    localparam int CNT_W     = 5;
    localparam logic [1:0] MODE_SPECIAL = 2'h0;

    // Control register field positions
    localparam int CTRL_PD_BIT   = 0;
    localparam int CTRL_TSD_BIT  = 1;
    localparam int CTRL_BANK_BIT = 2;
    localparam int CTRL_RSV_BIT  = 3;
    localparam int CTRL_OVT_BIT  = 4;

    // Function codes
    localparam logic [5:0] FC_NOP   = 6'h00;
    localparam logic [5:0] FC_CTRL  = 6'h01;
    localparam logic [5:0] FC_OFFSET_DAC_ZERO_DATA  = 6'h02;
    localparam logic [5:0] FC_OFFSET_DAC_ONE_DATA  = 6'h03;
    localparam logic [5:0] FC_RBSEL = 6'h05;
    localparam logic [5:0] FC_ABS0  = 6'h06;
    localparam logic [5:0] FC_ABALL = 6'h0b;

    // Readback address fields, payload bits 15..7
    localparam int RB_KIND_HI = 15;
    localparam int RB_KIND_LO = 13;
    localparam int RB_ADDR_HI = 12;
    localparam int RB_ADDR_LO = 7;
    localparam logic [8:0] RBA_CTRL = 9'h101;
    localparam logic [8:0] RBA_OFFSET_DAC_ZERO_DATA = 9'h102;
    localparam logic [8:0] RBA_OFFSET_DAC_ONE_DATA = 9'h103;
    localparam logic [8:0] RBA_ABS0 = 9'h106;

    // Reset values
    localparam logic [2:0]       CTRL_RST = 3'h0;
    localparam logic [OFS_W-1:0] OFS_RST  = 14'h0000;
    localparam logic [ABS_W-1:0] ABS_RST  = 8'h00;

    // Readback source
    typedef enum logic [2:0] {
        RB_NONE = 3'b000,
        RB_CHAN = 3'b001,
        RB_CTRL = 3'b010,
        RB_OFFSET_DAC_ZERO_DATA = 3'b011,
        RB_OFFSET_DAC_ONE_DATA = 3'b100,
        RB_ABS  = 3'b101
    } dsfd_rb_src_t;
endpackage

// ===== hw/dsfd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dsfd_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // Two stages; the first is read only by the second.
    // Reset to the pin's idle level so no false edge follows reset
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            meta_q   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== hw/dsfd_rx.sv
`timescale 1ns/1ps
`default_nettype none
module dsfd_rx
    import dsfd_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire logic              in_frame,
    input  wire logic              bit_strobe,
    input  wire logic              bit_in,
    output logic      [WORD_W-1:0] word_q,
    output logic                   word_vld_q
);
    logic [WORD_W-1:0] shift_q;
    logic [CNT_W-1:0]  cnt_q;
    wire               last_bit = (cnt_q == CNT_W'(WORD_W - 1));
    wire  [WORD_W-1:0] shift_d  = {shift_q[WORD_W-2:0], bit_in};

    // Bits beyond the 24th in one frame are dropped
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            shift_q    <= '0;
            cnt_q      <= '0;
            word_q     <= '0;
            word_vld_q <= 1'b0;
        end else begin
            word_vld_q <= 1'b0;
            if (!in_frame) begin
                cnt_q <= '0;
            end else if (bit_strobe && cnt_q < CNT_W'(WORD_W)) begin
                shift_q <= shift_d;
                cnt_q   <= cnt_q + 1'b1;
                if (last_bit) begin
                    word_q     <= shift_d;
                    word_vld_q <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== hw/dsfd_top.sv
// Overview of operation
// - Word with both mode bits zero is a special-function command.
// - Bits 21..16 hold function code, bits 15..0 the payload.
// - Channel data goes to input register A if bank bit 0, else B.
// - Code 000001 writes control; bit 4 overtemperature is never stored.
// - Control bit 2 picks input register B when 1, A when 0.
// - Control bit 1 enables thermal shutdown mode.
// - Control bit 0 sets software power-down.
// - Code 000010 loads low 14 payload bits into offset DAC 0.
// - Code 000011 loads low 14 payload bits into offset DAC 1.
// - Code 000101 latches readback address for the next transfer.
// - Codes 000110 to 001001 write low byte to source select 0..3.
// - Code 001011 writes low byte into all four source selects.
// - Readback bits 15..13 000..011 pick channel A, B, offset, gain.
// - Readback 100000110..100001001 picks source select 0..3.
// - Payload bits 6..0 are ignored for readback select.
`timescale 1ns/1ps
`default_nettype none
module dsfd_top
    import dsfd_pkg::*;
(
    input  wire logic                        clock,
    input  wire logic                        rst_b,
    input  wire logic                        sclk,
    input  wire logic                        sync_b,
    input  wire logic                        sdi,
    input  wire logic                        overtemp,
    input  wire logic [PAY_W-1:0]            chan_rb_data,
    output logic                             sdo_q,
    output logic                             bank_sel_q,
    output logic                             thermal_sd_en_q,
    output logic                             soft_pd_q,
    output logic      [OFS_W-1:0]            offset_dac_zero_data_q,
    output logic      [OFS_W-1:0]            offset_dac_one_data_q,
    output logic      [ABS_N-1:0][ABS_W-1:0] bank_source_select_q,
    output logic      [WORD_W-1:0]           chan_word_q,
    output logic                             chan_wr_a_q,
    output logic                             chan_wr_b_q,
    output logic      [1:0]                  rb_chan_kind_q,
    output logic      [5:0]                  rb_chan_addr_q
);
    // Pin synchronisers; sclk is slow enough to sample
    logic [3:0] pins_s;
    logic       sclk_d_q;
    logic       frame_d_q;

    // sclk idles high, so its stage resets high
    dsfd_sync #(.W(4), .RST_VAL(4'h8)) u_sync (
        .clock    (clock),
        .rst_b    (rst_b),
        .async_in ({sclk, ~sync_b, sdi, overtemp}),
        .sync_out (pins_s)
    );

    wire sclk_s     = pins_s[3];
    wire in_frame   = pins_s[2];
    wire sdi_s      = pins_s[1];
    wire ovt_s      = pins_s[0];
    wire sclk_fall  = sclk_d_q & ~sclk_s;
    wire sclk_rise  = ~sclk_d_q & sclk_s;
    wire frame_open = in_frame & ~frame_d_q;

    // Edge history
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sclk_d_q  <= 1'b1;
            frame_d_q <= 1'b0;
        end else begin
            sclk_d_q  <= sclk_s;
            frame_d_q <= in_frame;
        end
    end

    logic [WORD_W-1:0] word;
    logic              word_vld;

    dsfd_rx u_rx (
        .clock      (clock),
        .rst_b      (rst_b),
        .in_frame   (in_frame),
        .bit_strobe (sclk_fall),
        .bit_in     (sdi_s),
        .word_q     (word),
        .word_vld_q (word_vld)
    );

    // Command decode
    // special word test
    wire             is_special = (word[MODE_HI:MODE_LO] == MODE_SPECIAL);
    wire [5:0]       code       = word[CODE_HI:CODE_LO];
    wire [PAY_W-1:0] pay        = word[PAY_W-1:0];
    wire             sf_vld     = word_vld & is_special;
    wire             wr_ctrl    = sf_vld & (code == FC_CTRL);
    wire             wr_offset_dac_zero_data    = sf_vld & (code == FC_OFFSET_DAC_ZERO_DATA);
    wire             wr_offset_dac_one_data    = sf_vld & (code == FC_OFFSET_DAC_ONE_DATA);
    wire             wr_rbsel   = sf_vld & (code == FC_RBSEL);
    wire             wr_aball   = sf_vld & (code == FC_ABALL);

    // Readback address decode
    function automatic dsfd_rb_src_t rb_decode(input logic [PAY_W-1:0] p);
        logic [8:0] a;
        a = p[RB_KIND_HI:RB_ADDR_LO];
        if (!p[RB_KIND_HI])
            rb_decode = (p[RB_KIND_HI-1:RB_KIND_LO] <= 2'h3) ? RB_CHAN : RB_NONE;
        else if (a == RBA_CTRL)
            rb_decode = RB_CTRL;
        else if (a == RBA_OFFSET_DAC_ZERO_DATA)
            rb_decode = RB_OFFSET_DAC_ZERO_DATA;
        else if (a == RBA_OFFSET_DAC_ONE_DATA)
            rb_decode = RB_OFFSET_DAC_ONE_DATA;
        else if (a >= RBA_ABS0 && a <= RBA_ABS0 + 9'h003)
            rb_decode = RB_ABS;
        else
            rb_decode = RB_NONE;
    endfunction

    // low payload bits never reach the decode
    wire dsfd_rb_src_t rb_src_d  = rb_decode(pay);
    wire [1:0]         rb_abs_d  = 2'(pay[RB_ADDR_LO+1:RB_ADDR_LO] - RBA_ABS0[1:0]);

    // Control register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            {bank_sel_q, thermal_sd_en_q, soft_pd_q} <= CTRL_RST;
        end else if (wr_ctrl) begin
            // bits 4 and 3 are not stored
            bank_sel_q      <= pay[CTRL_BANK_BIT];
            thermal_sd_en_q <= pay[CTRL_TSD_BIT];
            soft_pd_q       <= pay[CTRL_PD_BIT];
        end
    end

    // Offset DAC registers, top two payload bits dropped
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            offset_dac_zero_data_q <= OFS_RST;
            offset_dac_one_data_q  <= OFS_RST;
        end else begin
            if (wr_offset_dac_zero_data)
                offset_dac_zero_data_q <= pay[OFS_W-1:0];
            if (wr_offset_dac_one_data)
                offset_dac_one_data_q <= pay[OFS_W-1:0];
        end
    end

    // Source select registers, one per code or all at once
    genvar gi;
    generate
        for (gi = 0; gi < ABS_N; gi++) begin : g_abs
            wire hit = sf_vld & ((code == FC_ABS0 + 6'(gi)) | (code == FC_ABALL));
            always_ff @(posedge clock) begin
                if (!rst_b)
                    bank_source_select_q[gi] <= ABS_RST;
                else if (hit)
                    bank_source_select_q[gi] <= pay[ABS_W-1:0];
            end
        end
    endgenerate

    // Readback selection; armed until the following word completes
    dsfd_rb_src_t rb_src_q;
    logic [1:0]   rb_abs_q;
    logic         rb_armed_q;

    // latch the address, reserved ones arm nothing
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rb_src_q       <= RB_NONE;
            rb_abs_q       <= 2'h0;
            rb_armed_q     <= 1'b0;
            rb_chan_kind_q <= 2'h0;
            rb_chan_addr_q <= 6'h00;
        end else if (wr_rbsel) begin
            rb_src_q       <= rb_src_d;
            rb_abs_q       <= rb_abs_d;
            rb_armed_q     <= (rb_src_d != RB_NONE);
            rb_chan_kind_q <= pay[RB_KIND_LO+1:RB_KIND_LO];
            rb_chan_addr_q <= pay[RB_ADDR_HI:RB_ADDR_LO];
        end else if (word_vld) begin
            rb_armed_q <= 1'b0;
        end
    end

    // Readback value, right-justified in the 24-bit frame
    // live overtemperature in bit 4, reserved bit 3 reads 0
    wire [4:0]       ctrl_rd = {ovt_s, 1'b0, bank_sel_q, thermal_sd_en_q, soft_pd_q};
    logic [PAY_W-1:0] rb_val;
    always_comb begin
        case (rb_src_q)
            RB_CHAN: rb_val = chan_rb_data;
            RB_CTRL: rb_val = PAY_W'(ctrl_rd);
            RB_OFFSET_DAC_ZERO_DATA: rb_val = PAY_W'(offset_dac_zero_data_q);
            RB_OFFSET_DAC_ONE_DATA: rb_val = PAY_W'(offset_dac_one_data_q);
            RB_ABS:  rb_val = PAY_W'(bank_source_select_q[rb_abs_q]);
            default: rb_val = '0;
        endcase
    end

    // Output shifter: loaded at frame open, shifted on rising sclk
    // data leaves during the frame after the select
    logic [WORD_W-1:0] tx_q;
    always_ff @(posedge clock) begin
        if (!rst_b)
            tx_q <= '0;
        else if (frame_open)
            tx_q <= rb_armed_q ? WORD_W'(rb_val) : '0;
        else if (in_frame && sclk_rise)
            tx_q <= {tx_q[WORD_W-2:0], 1'b0};
    end

    // Quiet low between frames
    always_ff @(posedge clock) begin
        if (!rst_b)
            sdo_q <= 1'b0;
        else
            sdo_q <= in_frame ? tx_q[WORD_W-1] : 1'b0;
    end

    // Channel write routing for the non-special words
    // bank bit steers the input register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            chan_word_q <= '0;
            chan_wr_a_q <= 1'b0;
            chan_wr_b_q <= 1'b0;
        end else begin
            chan_wr_a_q <= word_vld & ~is_special & ~bank_sel_q;
            chan_wr_b_q <= word_vld & ~is_special & bank_sel_q;
            if (word_vld && !is_special)
                chan_word_q <= word;
        end
    end

    // special words never reach the channel path
    a_special_no_chan: assert property (@(posedge clock) disable iff (!rst_b)
        sf_vld |=> !chan_wr_a_q && !chan_wr_b_q)
        else $error("special word produced a channel write");

    a_chan_route_bank: assert property (@(posedge clock) disable iff (!rst_b)
        (word_vld && !is_special) |=> (chan_wr_b_q == $past(bank_sel_q)) && (chan_wr_a_q != chan_wr_b_q))
        else $error("channel write routed to wrong register");

    // bit 4 of the payload does not land in storage
    a_ctrl_write_load: assert property (@(posedge clock) disable iff (!rst_b)
        wr_ctrl |=> {bank_sel_q, thermal_sd_en_q, soft_pd_q} == $past(pay[2:0]))
        else $error("control register write not stored");

    // power-down holds without a control write
    a_pd_hold: assert property (@(posedge clock) disable iff (!rst_b)
        !wr_ctrl |=> $stable(soft_pd_q) && $stable(thermal_sd_en_q) && $stable(bank_sel_q))
        else $error("control bits changed without a write");

    a_offset_dac_zero_data_load: assert property (@(posedge clock) disable iff (!rst_b)
        wr_offset_dac_zero_data |=> offset_dac_zero_data_q == $past(pay[13:0]))
        else $error("offset DAC 0 not loaded");

    a_offset_dac_one_data_load: assert property (@(posedge clock) disable iff (!rst_b)
        wr_offset_dac_one_data |=> offset_dac_one_data_q == $past(pay[13:0]))
        else $error("offset DAC 1 not loaded");

    // offset DAC 1 holds between writes
    a_offset_dac_one_data_hold: assert property (@(posedge clock) disable iff (!rst_b)
        !wr_offset_dac_one_data |=> $stable(offset_dac_one_data_q))
        else $error("offset DAC 1 changed without a write");

    a_block_write: assert property (@(posedge clock) disable iff (!rst_b)
        wr_aball |=> bank_source_select_q == {ABS_N{$past(pay[ABS_W-1:0])}})
        else $error("block source select write incomplete");

    // a write to source select 0 loads it and leaves source select 1 alone
    a_abs_single: assert property (@(posedge clock) disable iff (!rst_b)
        (sf_vld && code == FC_ABS0) |=> bank_source_select_q[0] == $past(pay[7:0]) &&
                                        $stable(bank_source_select_q[1]))
        else $error("source select 0 write wrong");

    // offset DAC 0 select arms the following frame
    a_rb_arm: assert property (@(posedge clock) disable iff (!rst_b)
        (wr_rbsel && rb_src_d == RB_OFFSET_DAC_ZERO_DATA) |=> rb_armed_q && rb_src_q == RB_OFFSET_DAC_ZERO_DATA)
        else $error("readback select not latched");

    // arming ends with the word that follows
    a_rb_disarm: assert property (@(posedge clock) disable iff (!rst_b)
        (word_vld && !wr_rbsel) |=> !rb_armed_q)
        else $error("readback stayed armed after a word");

    // a no-op word leaves offset DAC 0, the source selects and power-down alone
    a_nop_no_change: assert property (@(posedge clock) disable iff (!rst_b)
        (sf_vld && code == FC_NOP) |=> $stable(offset_dac_zero_data_q) &&
                                       $stable(bank_source_select_q) && $stable(soft_pd_q))
        else $error("no-op changed state");
endmodule
`default_nettype wire

// ===== dv/dsfd_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host controller on the far side of the serial port
module dsfd_host (
    input  wire logic clock,
    output logic      sclk,
    output logic      sync_b,
    output logic      sdi,
    input  wire logic sdo
);
    // Half an sclk period in system clocks: 400 ns link period
    localparam int HALF = 4;

    // Idle: clock high, frame off
    initial begin
        sclk = 1'b1;
        sync_b = 1'b1;
        sdi = 1'b0;
    end

    // One frame of n bits, driven on rising system clock edges; sdo moves
    // about four clocks after sclk rises, so it is taken just before a rise
    task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
        r = '0;
        @(posedge clock);
        sync_b <= 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi <= w[23-i];
            repeat (HALF) @(posedge clock);
            sclk <= 1'b0;
            repeat (HALF) @(posedge clock);
            r = {r[22:0], sdo};
            sclk <= 1'b1;
        end
        repeat (HALF) @(posedge clock);
        sync_b <= 1'b1;
        sdi <= ~sdi; // Released line: never the last value
        repeat (2 * HALF) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dsfd_pkg::*;
    logic                        clock, rst_b, overtemp;
    logic [PAY_W-1:0]            chan_rb_data;
    logic                        sclk, sync_b, sdi, sdo_q;
    logic                        bank_sel_q, thermal_sd_en_q, soft_pd_q;
    logic [OFS_W-1:0]            offset_dac_zero_data, offset_dac_one_data;
    logic [ABS_N-1:0][ABS_W-1:0] abs_q;
    logic [WORD_W-1:0]           chan_word_q;
    logic                        chan_wr_a_q, chan_wr_b_q;
    logic [1:0]                  kind_q;
    logic [5:0]                  addr_q;
    int                          n_fail, checks_done, n_a, n_b;

    dsfd_top u_dsfd_top (.clock(clock), .rst_b(rst_b), .sclk(sclk), .sync_b(sync_b),
        .sdi(sdi), .overtemp(overtemp), .chan_rb_data(chan_rb_data), .sdo_q(sdo_q),
        .bank_sel_q(bank_sel_q), .thermal_sd_en_q(thermal_sd_en_q), .soft_pd_q(soft_pd_q),
        .offset_dac_zero_data_q(offset_dac_zero_data), .offset_dac_one_data_q(offset_dac_one_data),
        .bank_source_select_q(abs_q), .chan_word_q(chan_word_q),
        .chan_wr_a_q(chan_wr_a_q), .chan_wr_b_q(chan_wr_b_q),
        .rb_chan_kind_q(kind_q), .rb_chan_addr_q(addr_q));
    dsfd_host u_dsfd_host (.clock(clock), .sclk(sclk), .sync_b(sync_b), .sdi(sdi), .sdo(sdo_q));

    // 20 MHz system clock
    initial clock = 1'b0;
    always #25 clock = ~clock;

    // Count one-cycle write pulses, they are too short to poll
    always @(posedge clock) begin
        if (chan_wr_a_q === 1'b1) n_a++;
        if (chan_wr_b_q === 1'b1) n_b++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic sf(input logic [5:0] code, input logic [15:0] pay);
        logic [23:0] r;
        u_dsfd_host.xfer({MODE_SPECIAL, code, pay}, 24, r);
    endtask

    // select then a no-op frame clocks the value out
    task automatic rb(input logic [15:0] sel, input logic [23:0] exp);
        logic [23:0] r;
        sf(FC_RBSEL, sel);
        u_dsfd_host.xfer({MODE_SPECIAL, FC_NOP, 16'h0000}, 24, r);
        check(r, exp);
    endtask

    task automatic t_reset;
        check({sdo_q, bank_sel_q, thermal_sd_en_q, soft_pd_q}, 32'h0);
        check({offset_dac_zero_data, offset_dac_one_data}, 32'h0);
        check(abs_q, 32'h0);
        check({kind_q, addr_q, chan_word_q}, 32'h0);
    endtask

    // Reset in mid-run returns every output register to zero
    task automatic t_midrst;
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        t_reset();
    endtask

    // Overtemperature written as 1 must not stick, but reads back live
    task automatic t_ctrl;
        sf(FC_CTRL, 16'hfff5);
        check({bank_sel_q, thermal_sd_en_q, soft_pd_q}, 32'h5);
        rb(16'h80ff, 24'h000005);
        @(posedge clock);
        overtemp <= 1'b1;
        sf(FC_CTRL, 16'h0002);
        check({bank_sel_q, thermal_sd_en_q, soft_pd_q}, 32'h2);
        rb(16'h8080, 24'h000012);
    endtask

    task automatic t_ofs;
        sf(FC_OFFSET_DAC_ZERO_DATA, 16'hffff);
        check(offset_dac_zero_data, 32'h3fff);
        sf(FC_OFFSET_DAC_ONE_DATA, 16'hc123);
        check(offset_dac_one_data, 32'h0123);
        check(offset_dac_zero_data, 32'h3fff);
        rb(16'h8100, 24'h003fff);
        rb(16'h81d5, 24'h000123);
    endtask

    task automatic t_abs;
        for (int i = 0; i < ABS_N; i++) begin
            sf(6'(FC_ABS0 + i), {8'hff, 8'(8'h30 + i)});
            check(abs_q[i], 32'h30 + i);
        end
        for (int i = 0; i < ABS_N; i++) begin
            rb({9'(RBA_ABS0 + i), 7'h2a}, 24'(8'h30 + i));
        end
        sf(FC_ABALL, 16'h00ff);
        check(abs_q, 32'hffffffff);
        sf(FC_ABALL, 16'hff00);
        check(abs_q, 32'h0);
    endtask

    // Reserved codes, reserved readback address and a short frame
    task automatic t_rsvd;
        logic [23:0] r;
        sf(6'h04, 16'hffff);
        sf(6'h0a, 16'hffff);
        sf(6'h3f, 16'hffff);
        sf(FC_NOP, 16'h0000);
        sf(FC_RBSEL, 16'h8100);
        sf(FC_RBSEL, 16'h8200);
        u_dsfd_host.xfer({MODE_SPECIAL, FC_OFFSET_DAC_ZERO_DATA, 16'h1111}, 12, r);
        check({offset_dac_zero_data, offset_dac_one_data}, {14'h3fff, 14'h0123});
        check({abs_q[0], bank_sel_q, thermal_sd_en_q, soft_pd_q}, 32'h2);
        u_dsfd_host.xfer({MODE_SPECIAL, FC_NOP, 16'h0000}, 24, r);
        check(r, 32'h0);
    endtask

    // Non-special words go to register A or B by bank bit
    task automatic t_chan;
        logic [23:0] r;
        n_a = 0;
        n_b = 0;
        u_dsfd_host.xfer(24'hc01234, 24, r);
        check(chan_word_q, 32'hc01234);
        check({n_a[7:0], n_b[7:0]}, 32'h0100);
        sf(FC_CTRL, 16'h0004);
        check({n_a[7:0], n_b[7:0]}, 32'h0100);
        u_dsfd_host.xfer(24'h41abcd, 24, r);
        check({n_a[7:0], n_b[7:0]}, 32'h0101);
        check(chan_word_q, 32'h41abcd);
    endtask

    // Channel readback: kind in 14..13, address in 12..7
    task automatic t_chrb;
        for (int k = 0; k < 4; k++) begin
            sf(FC_RBSEL, {1'b0, 2'(k), 6'(k + 9), 7'h7f});
            check({kind_q, addr_q}, {2'(k), 6'(k + 9)});
        end
        @(posedge clock);
        chan_rb_data <= 16'hbeef;
        rb(16'h2280, 24'h00beef);
        check({kind_q, addr_q}, {2'h1, 6'h05});
    endtask

    initial begin
        rst_b = 1'b0;
        overtemp = 1'b0;
        chan_rb_data = 16'h0;
        n_fail = 0;
        checks_done = 0;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        t_reset();
        t_ctrl();
        t_ofs();
        t_abs();
        t_rsvd();
        t_chan();
        t_chrb();
        t_midrst();
        test_done();
    end

    // Watchdog: about 45 frames of 10 us are expected
    initial begin
        #2000000;
        n_fail++;
        test_done();
    end
endmodule
`default_nettype wire
